// File: rtl/smc_pkg.sv
// Constants, types and decode helpers of the step clock motor sequencer.
// Assumes a single 20 MHz clock domain; shared by the sequencer top and the bench.
package smc_pkg;
	localparam int             REF_CLK_KHZ     = 20000;
	localparam int             OSC_FREQ_KHZ    = 1120;
	localparam int             OSC_DIV_W       = 16;
	localparam int             ANGLE_W         = 7;
	localparam int             PCT_W           = 7;
	localparam logic [6:0]     INIT_ANGLE      = 7'h10;
	localparam logic [6:0]     PCT_FULL        = 7'h64;
	localparam logic [5:0]     QUAD_STEPS      = 6'h20;
	localparam logic [3:0]     CHOP_LAST_PHASE = 4'hF;
	localparam logic [3:0]     FAST_LL         = 4'h2;
	localparam logic [3:0]     FAST_LH         = 4'h6;
	localparam logic [3:0]     FAST_HL         = 4'h8;
	localparam logic [2:0]     RES_STANDBY     = 3'h0;
	localparam logic [2:0]     RES_FULL        = 3'h1;
	localparam logic [2:0]     RES_HALF_A      = 3'h2;
	localparam logic [2:0]     RES_QUARTER     = 3'h3;
	localparam logic [2:0]     RES_HALF_B      = 3'h4;
	localparam logic [2:0]     RES_EIGHTH      = 3'h5;
	localparam logic [2:0]     RES_SIXTEENTH   = 3'h6;
	localparam logic [1:0]     DECAY_FAST_ONLY = 2'h3;
	localparam logic [3:0]     CSR_CTRL        = 4'h0;
	localparam logic [3:0]     CSR_STATUS      = 4'h4;

	typedef enum logic [1:0] {
		CHOP_CHARGE = 2'b00,
		CHOP_FAST   = 2'b01,
		CHOP_SLOW   = 2'b11
	} smc_chop_t;

	typedef struct packed {
		logic posOut;
		logic posOe;
		logic negOut;
		logic negOe;
	} smc_coil_t;

	// Angle increment per step clock rising edge, in 1/32 micro steps
	function automatic logic [6:0] smcStepSize(input logic [2:0] res);
		unique case (res)
			RES_FULL:               smcStepSize = 7'h20;
			RES_HALF_A, RES_HALF_B: smcStepSize = 7'h10;
			RES_QUARTER:            smcStepSize = 7'h08;
			RES_EIGHTH:             smcStepSize = 7'h04;
			RES_SIXTEENTH:          smcStepSize = 7'h02;
			default:                smcStepSize = 7'h01;
		endcase
	endfunction : smcStepSize

	// Current percentage at k micro steps from the zero crossing
	function automatic logic [6:0] smcSinePct(input logic [5:0] k);
		logic [6:0] tbl [0:32];
		tbl = '{7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1D, 7'h22, 7'h26, 7'h2B, 7'h2F,
			7'h34, 7'h38, 7'h3C, 7'h3F, 7'h43, 7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56,
			7'h58, 7'h5A, 7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h63, 7'h64, 7'h64};
		smcSinePct = (k > QUAD_STEPS) ? PCT_FULL : tbl[k];
	endfunction : smcSinePct
endpackage : smc_pkg

// File: rtl/smc_sequencer.sv
// Step clock sequencer: angle counter, phase current table, chopper and Avalon-MM CSRs.
// Assumes all pin inputs synchronous to ref_clk; bridge pins resolved outside.
// How it works
// - Each step clock rising edge outside standby and angle reset moves the angle one step of the chosen resolution.
// - A step clock falling edge changes neither angle nor currents.
// - Enable high drives both bridges outside standby and shutdown; enable low puts all bridge legs in high impedance.
// - Direction high: channel A current leads channel B by 90 degrees.
// - Direction low: channel B current leads channel A by 90 degrees.
// - Charge drives positive leg high, negative low clockwise; reversed counter-clockwise.
// - All resolution bits low selects standby: oscillator stopped, all bridge outputs off.
// - Resolution bits decode to full, half A, quarter, half B, 1/8, 1/16, 1/32.
// - Decay bits give fast decay of 2, 6, 8 oscillator periods, or fast only.
// - Angle reset high forces the initial angle; low gives normal operation.
// - In reset origin flag is low, angle 45 degrees, 100 or 71 percent.
// - Thermal or overcurrent shutdown pulls the open-drain fault flag low.
// - Charge outlasting a chopping cycle continues until the current limit is hit.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module smc_sequencer #(
	parameter logic [15:0] OSC_DIV_DEFAULT = 16'(smc_pkg::REF_CLK_KHZ / smc_pkg::OSC_FREQ_KHZ)
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             stepClock,
	input  wire logic             outputEnable,
	input  wire logic             angleReset,
	input  wire logic             rotationDirection,
	input  wire logic             stepResSelBit0,
	input  wire logic             stepResSelBit1,
	input  wire logic             stepResSelBit2,
	input  wire logic             decayRatioSelBit0,
	input  wire logic             decayRatioSelBit1,
	input  wire logic             currentLimitHitA,
	input  wire logic             currentLimitHitB,
	input  wire logic             thermalShutdown,
	input  wire logic             overcurrentShutdown,
	output smc_pkg::smc_coil_t    coilA,
	output smc_pkg::smc_coil_t    coilB,
	output logic [6:0]            coilACurrentPct,
	output logic [6:0]            coilBCurrentPct,
	output logic                  angleOriginFlag,
	output logic                  angleOriginFlagOe,
	output logic                  faultFlagN,
	output logic                  faultFlagNOe,
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic [31:0]           avs_readdata,
	output logic                  avs_waitrequest
);
	import smc_pkg::*;

	logic [2:0]            resSel;
	logic [1:0]            decaySel;
	logic                  standby;
	logic                  fault;
	logic                  run;
	logic                  stepRise;
	logic                  stepFall;
	logic                  stepPrevQ,  stepPrevD;
	logic [6:0]            angleQ,     angleD;
	logic [6:0]            pctAQ,      pctAD;
	logic [6:0]            pctBQ,      pctBD;
	logic [15:0]           oscCntQ,    oscCntD;
	logic [3:0]            phaseQ,     phaseD;
	logic [15:0]           oscDivQ,    oscDivD;
	logic                  respQ,      respD;
	logic [31:0]           rdataQ,     rdataD;
	logic                  oscTick;
	logic                  cycleStart;
	logic [3:0]            fastLen;
	logic [1:0]            limitHit;
	logic [1:0]            curSign;
	logic [1:0]            curZero;
	smc_coil_t             coil [2];

	assign resSel   = {stepResSelBit0, stepResSelBit1, stepResSelBit2};
	assign decaySel = {decayRatioSelBit0, decayRatioSelBit1};
	assign standby  = (resSel == RES_STANDBY);
	assign fault    = thermalShutdown | overcurrentShutdown;
	assign run      = outputEnable & ~standby & ~fault;
	assign stepRise = stepClock & ~stepPrevQ;
	assign stepFall = ~stepClock & stepPrevQ;
	assign limitHit = {currentLimitHitB, currentLimitHitA};

	// Angle counter and phase currents
	always_comb begin
		logic [1:0] quad;
		logic [5:0] k;
		logic [6:0] sinB;
		logic [6:0] cosA;
		sinB      = '0;
		cosA      = '0;
		quad      = angleQ[6:5];
		k         = {1'b0, angleQ[4:0]};
		stepPrevD = stepClock;
		angleD    = angleQ;
		if (angleReset) begin
			angleD = INIT_ANGLE;
		end else if (stepRise && !standby) begin
			angleD = rotationDirection ? angleQ + smcStepSize(resSel)
				: angleQ - smcStepSize(resSel);
		end
		sinB = quad[0] ? smcSinePct(QUAD_STEPS - k) : smcSinePct(k);
		cosA = quad[0] ? smcSinePct(k) : smcSinePct(QUAD_STEPS - k);
		if (resSel == RES_FULL || resSel == RES_HALF_A) begin
			cosA = (cosA != '0) ? PCT_FULL : '0;
			sinB = (sinB != '0) ? PCT_FULL : '0;
		end
		pctAD   = cosA;
		pctBD   = sinB;
		curSign = {~quad[1], quad[1] ~^ quad[0]};
		curZero = {pctBQ == '0, pctAQ == '0};
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stepPrevQ <= 1'b0;
			angleQ    <= INIT_ANGLE;
			pctAQ     <= '0;
			pctBQ     <= '0;
		end else begin
			stepPrevQ <= stepPrevD;
			angleQ    <= angleD;
			pctAQ     <= pctAD;
			pctBQ     <= pctBD;
		end
	end

	// Chopping oscillator, stopped in standby
	always_comb begin
		oscTick = !standby && (oscCntQ + 16'h0001 >= oscDivQ);
		oscCntD = standby ? '0 : (oscTick ? '0 : oscCntQ + 16'h0001);
		phaseD  = standby ? '0 : (oscTick ? phaseQ + 4'h1 : phaseQ);
		unique case (decaySel)
			2'h0:    fastLen = FAST_LL;
			2'h1:    fastLen = FAST_LH;
			2'h2:    fastLen = FAST_HL;
			default: fastLen = '0;
		endcase
	end
	assign cycleStart = oscTick && (phaseQ == CHOP_LAST_PHASE);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			oscCntQ <= '0;
			phaseQ  <= '0;
		end else begin
			oscCntQ <= oscCntD;
			phaseQ  <= phaseD;
		end
	end

	// Per-channel chopper and bridge legs
	for (genvar c = 0; c < 2; c++) begin : gChop
		smc_chop_t  chopQ,    chopD;
		logic [3:0] fastCntQ, fastCntD;
		logic       pol;
		always_comb begin
			chopD    = chopQ;
			fastCntD = fastCntQ;
			if (!run) begin
				chopD    = CHOP_CHARGE;
				fastCntD = '0;
			end else begin
				unique case (chopQ)
					CHOP_CHARGE: if (limitHit[c]) begin
						chopD    = CHOP_FAST;
						fastCntD = fastLen;
					end
					CHOP_FAST: if (cycleStart) begin
						chopD = CHOP_CHARGE;
					end else if (decaySel != DECAY_FAST_ONLY && oscTick) begin
						fastCntD = fastCntQ - 4'h1;
						if (fastCntQ <= 4'h1) begin
							chopD = CHOP_SLOW;
						end
					end
					CHOP_SLOW: if (cycleStart) begin
						chopD = CHOP_CHARGE;
					end
				endcase
			end
			pol = curSign[c] ~^ rotationDirection;
			coil[c].posOe  = run;
			coil[c].negOe  = run;
			coil[c].posOut = 1'b0;
			coil[c].negOut = 1'b0;
			if (!curZero[c] && chopQ == CHOP_CHARGE) begin
				coil[c].posOut = pol;
				coil[c].negOut = ~pol;
			end else if (!curZero[c] && chopQ == CHOP_FAST) begin
				coil[c].posOut = ~pol;
				coil[c].negOut = pol;
			end
		end
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				chopQ    <= CHOP_CHARGE;
				fastCntQ <= '0;
			end else begin
				chopQ    <= chopD;
				fastCntQ <= fastCntD;
			end
		end
		AST_CHARGE_EXTENDS: assert property (@(posedge ref_clk) disable iff (srst)
			run && chopQ == CHOP_CHARGE && !limitHit[c] |=> chopQ == CHOP_CHARGE)
			else $error("charge ended without current limit");
	end

	assign coilA             = coil[0];
	assign coilB             = coil[1];
	assign coilACurrentPct   = pctAQ;
	assign coilBCurrentPct   = pctBQ;
	assign angleOriginFlag   = 1'b0;
	assign angleOriginFlagOe = (angleQ == INIT_ANGLE);
	assign faultFlagN        = 1'b0;
	assign faultFlagNOe      = fault;

	// Avalon-MM slave, one wait state per access
	always_comb begin
		oscDivD = oscDivQ;
		respD   = (avs_read | avs_write) & ~respQ;
		rdataD  = '0;
		if (avs_write && respQ && avs_address == CSR_CTRL) begin
			if (avs_byteenable[0]) oscDivD[7:0] = avs_writedata[7:0];
			if (avs_byteenable[1]) oscDivD[15:8] = avs_writedata[15:8];
		end
		if (avs_address == CSR_CTRL) begin
			rdataD = {16'h0000, oscDivQ};
		end else if (avs_address == CSR_STATUS) begin
			rdataD = {21'h0, fault, standby, angleOriginFlagOe, 1'b0, angleQ};
		end
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~respQ;
	assign avs_readdata    = rdataQ;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			oscDivQ <= OSC_DIV_DEFAULT;
			respQ   <= 1'b0;
			rdataQ  <= '0;
		end else begin
			oscDivQ <= oscDivD;
			respQ   <= respD;
			rdataQ  <= rdataD;
		end
	end

	AST_STEP_CW: assert property (@(posedge ref_clk) disable iff (srst)
		stepRise && !standby && !angleReset && rotationDirection
		|=> angleQ == $past(angleQ) + smcStepSize($past(resSel)))
		else $error("clockwise step size wrong");
	AST_STEP_CCW: assert property (@(posedge ref_clk) disable iff (srst)
		stepRise && !standby && !angleReset && !rotationDirection
		|=> angleQ == $past(angleQ) - smcStepSize($past(resSel)))
		else $error("counter-clockwise step size wrong");
	AST_FALL_HOLDS: assert property (@(posedge ref_clk) disable iff (srst)
		stepFall && !angleReset |=> $stable(angleQ))
		else $error("angle moved on falling edge");
	AST_DISABLED_HIZ: assert property (@(posedge ref_clk) disable iff (srst)
		!outputEnable |-> !coilA.posOe && !coilA.negOe && !coilB.posOe && !coilB.negOe)
		else $error("bridge driven while disabled");
	AST_STANDBY: assert property (@(posedge ref_clk) disable iff (srst)
		standby && !angleReset |-> !oscTick && !coilA.posOe ##1 $stable(angleQ))
		else $error("standby not honoured");
	AST_RESET_ANGLE: assert property (@(posedge ref_clk) disable iff (srst)
		angleReset |=> angleQ == INIT_ANGLE && angleOriginFlagOe && !angleOriginFlag)
		else $error("angle reset not applied");
	AST_RESET_PCT: assert property (@(posedge ref_clk) disable iff (srst)
		angleReset [*3] ##0 $stable(resSel) |-> pctAQ == pctBQ
		&& (pctAQ == PCT_FULL) == (resSel == RES_FULL || resSel == RES_HALF_A))
		else $error("reset currents wrong");
	AST_FAULT_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
		faultFlagNOe == (thermalShutdown || overcurrentShutdown) && !faultFlagN)
		else $error("fault flag mismatch");
endmodule : smc_sequencer

// File: testbench/smc_motion_ctrl.sv
// Motion controller model: drives step, direction, enable, reset and resolution pins.
// Assumes one caller at a time; every pin changes right after a rising ref_clk edge.
`timescale 1ns/1ns
module smc_motion_ctrl (
	input  wire logic ref_clk,
	input  wire logic supplyUp,
	output logic      stepClock,
	output wire logic outputEnable,
	output logic      angleReset,
	output logic      rotationDirection,
	output logic      stepResSelBit0,
	output logic      stepResSelBit1,
	output logic      stepResSelBit2
);
	logic enReq;
	// Enable stays low until the motor supply is up
	assign outputEnable = supplyUp & enReq;
	initial begin
		stepClock = 1'b0;
		angleReset = 1'b0;
		rotationDirection = 1'b1;
		{stepResSelBit0, stepResSelBit1, stepResSelBit2} = 3'h0;
		enReq = 1'b0;
	end
	// Resolution only changes under angle reset
	task automatic setRes(input logic [2:0] r);
		@(posedge ref_clk);
		angleReset <= 1'b1;
		{stepResSelBit0, stepResSelBit1, stepResSelBit2} <= r;
	endtask : setRes
	task automatic relRst();
		@(posedge ref_clk);
		angleReset <= 1'b0;
	endtask : relRst
	task automatic setDir(input logic d);
		@(posedge ref_clk);
		rotationDirection <= d;
	endtask : setDir
	task automatic level(input logic v);
		@(posedge ref_clk);
		stepClock <= v;
	endtask : level
	task automatic enable(input logic e);
		@(posedge ref_clk);
		enReq <= e;
	endtask : enable
endmodule : smc_motion_ctrl

// File: testbench/tb.sv
// Bench of the step clock sequencer: pin stepping checked through Avalon status reads.
// Assumes smc_pkg, smc_sequencer and smc_motion_ctrl are compiled before it.
`timescale 1ns/1ns
module tb;
	import smc_pkg::*;
	localparam logic [6:0] STEP [1:7] = '{7'h20, 7'h10, 7'h08, 7'h10, 7'h04, 7'h02, 7'h01};
	logic        ref_clk = 1'b0;
	logic        srst, supplyUp, currentLimitHitA, currentLimitHitB;
	logic        thermalShutdown, overcurrentShutdown, decayRatioSelBit0, decayRatioSelBit1;
	logic [3:0]  avs_address, avs_byteenable;
	logic        avs_read, avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, stepClock, outputEnable, angleReset, rotationDirection;
	logic        stepResSelBit0, stepResSelBit1, stepResSelBit2;
	smc_coil_t   coilA, coilB;
	logic [6:0]  coilACurrentPct, coilBCurrentPct;
	logic        angleOriginFlag, angleOriginFlagOe, faultFlagN, faultFlagNOe;
	logic [3:0]  allOe;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;
	assign allOe = {coilA.posOe, coilA.negOe, coilB.posOe, coilB.negOe};
	always #25 ref_clk = ~ref_clk;
	smc_motion_ctrl u_smc_motion_ctrl (.ref_clk, .supplyUp, .stepClock, .outputEnable,
		.angleReset, .rotationDirection, .stepResSelBit0, .stepResSelBit1, .stepResSelBit2);
	smc_sequencer u_smc_sequencer (.ref_clk, .srst, .stepClock, .outputEnable, .angleReset,
		.rotationDirection, .stepResSelBit0, .stepResSelBit1, .stepResSelBit2,
		.decayRatioSelBit0, .decayRatioSelBit1, .currentLimitHitA, .currentLimitHitB,
		.thermalShutdown, .overcurrentShutdown, .coilA, .coilB, .coilACurrentPct,
		.coilBCurrentPct, .angleOriginFlag, .angleOriginFlagOe, .faultFlagN, .faultFlagNOe,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest);
	task automatic tally_and_finish();
		$display("Mismatches %0d, comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chkWord
	task automatic chkBit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chkBit
	// Request held until a rising edge samples waitrequest low; data taken there
	task automatic avXfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : avXfer
	task automatic chkStat(input logic [6:0] a, input logic sb, input logic f);
		avXfer(1'b0, CSR_STATUS, 32'h0);
		chkWord(rd, {21'h0, f, sb, a == 7'h10, 1'b0, a}, "status");
	endtask : chkStat
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : settle
	task automatic pulse();
		u_smc_motion_ctrl.level(1'b1);
		u_smc_motion_ctrl.level(1'b0);
	endtask : pulse
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		srst = 1'b1;
		{supplyUp, currentLimitHitA, currentLimitHitB} = 3'h0;
		{thermalShutdown, overcurrentShutdown, decayRatioSelBit0, decayRatioSelBit1} = 4'h0;
		avs_address = 4'h0;
		avs_byteenable = 4'hF;
		{avs_read, avs_write} = 2'h0;
		avs_writedata = 32'h0;
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		settle(1);
		chkWord(32'(allOe), 32'h0, "oe at power-up");
		avXfer(1'b0, CSR_CTRL, 32'h0);
		chkWord(rd, 32'h11, "divider default");
		avXfer(1'b1, CSR_CTRL, 32'hFFFF_0012);
		avs_byteenable <= 4'h1;
		avXfer(1'b1, CSR_CTRL, 32'h0000_FF12);
		avs_byteenable <= 4'hF;
		avXfer(1'b1, CSR_STATUS, 32'h0);
		avXfer(1'b0, 4'h8, 32'h0);
		chkWord(rd, 32'h0, "unmapped read");
		avXfer(1'b0, CSR_CTRL, 32'h0);
		chkWord(rd, 32'h12, "divider");
		chkStat(7'h10, 1'b1, 1'b0);
		for (int r = 1; r < 8; r++) begin
			u_smc_motion_ctrl.setRes(3'(r));
			{decayRatioSelBit0, decayRatioSelBit1} <= 2'(r);
			settle(3);
			chkWord(32'(coilACurrentPct), (r < 3) ? 32'h64 : 32'h47, "pctA reset");
			chkWord(32'(coilBCurrentPct), (r < 3) ? 32'h64 : 32'h47, "pctB reset");
			chkBit(angleOriginFlagOe, 1'b1, "origin reset");
			chkBit(angleOriginFlag, 1'b0, "origin pin value");
			pulse();
			u_smc_motion_ctrl.relRst();
			u_smc_motion_ctrl.setDir(1'b1);
			chkStat(7'h10, 1'b0, 1'b0);
			u_smc_motion_ctrl.level(1'b1);
			settle(2);
			chkStat(7'h10 + STEP[r], 1'b0, 1'b0);
			chkBit(angleOriginFlagOe, 1'b0, "origin off");
			u_smc_motion_ctrl.level(1'b0);
			chkStat(7'h10 + STEP[r], 1'b0, 1'b0);
			u_smc_motion_ctrl.setDir(1'b0);
			pulse();
			chkStat(7'h10, 1'b0, 1'b0);
			pulse();
			chkStat(7'h10 - STEP[r], 1'b0, 1'b0);
		end
		@(posedge ref_clk);
		supplyUp <= 1'b1;
		u_smc_motion_ctrl.enable(1'b1);
		u_smc_motion_ctrl.setRes(3'h0);
		u_smc_motion_ctrl.relRst();
		pulse();
		chkStat(7'h10, 1'b1, 1'b0);
		chkWord(32'(allOe), 32'h0, "standby oe");
		u_smc_motion_ctrl.setRes(3'h7);
		u_smc_motion_ctrl.setDir(1'b1);
		u_smc_motion_ctrl.relRst();
		settle(4);
		chkWord(32'(allOe), 32'hF, "enabled oe");
		chkWord(32'(coilA), 32'hD, "cw charge");
		u_smc_motion_ctrl.setDir(1'b0);
		settle(400);
		chkWord(32'(coilB), 32'h7, "ccw charge held");
		@(posedge ref_clk);
		currentLimitHitA <= 1'b1;
		currentLimitHitB <= 1'b1;
		{decayRatioSelBit0, decayRatioSelBit1} <= 2'h0;
		settle(10);
		chkWord(32'(coilB), 32'hD, "fast decay B");
		chkWord(32'(coilA), 32'hD, "fast decay A");
		settle(30);
		chkBit(coilB === 4'h7, 1'b0, "decay after limit");
		chkWord(32'(coilB), 32'h5, "slow after two periods");
		@(posedge ref_clk);
		thermalShutdown <= 1'b1;
		settle(1);
		chkBit(faultFlagNOe, 1'b1, "thermal flag");
		chkBit(faultFlagN, 1'b0, "fault pin value");
		chkStat(7'h10, 1'b0, 1'b1);
		@(posedge ref_clk);
		thermalShutdown <= 1'b0;
		overcurrentShutdown <= 1'b1;
		settle(1);
		chkBit(faultFlagNOe, 1'b1, "overcurrent flag");
		@(posedge ref_clk);
		overcurrentShutdown <= 1'b0;
		u_smc_motion_ctrl.enable(1'b0);
		settle(2);
		chkBit(faultFlagNOe, 1'b0, "flag released");
		chkWord(32'(allOe), 32'h0, "disabled oe");
		tally_and_finish();
	end
endmodule : tb
